/* File: design/asr_ctrl.sv */
`timescale 1ns/100ps
// host controller for the asynchronous 16k x 4 memory
module asr_ctrl
    import asr_pkg::*;
#(
    parameter int GRADE = 0, // 0, 1, 2 = 10, 12, 15 ns part
    parameter bit CS_WRITE = 1'b0 // 1: select-controlled writes
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [ASR_AW-1:0] i_addr,
    input wire logic [ASR_DW-1:0] i_wdata,
    output logic o_ready,
    output logic o_rvalid,
    output logic [ASR_DW-1:0] o_rdata,
    output logic [ASR_AW-1:0] o_word_index,
    output logic [ASR_DW-1:0] o_input_bit,
    output logic o_enable_chip_low_n,
    output logic o_store_strobe_n,
    input wire logic [ASR_DW-1:0] i_output_bit
);
    // one grade chosen for every interval
    localparam int C_RD = asr_cyc((ASR_T_AVQV_PS[GRADE] > ASR_T_SLSH_RD_PS) ?
        ASR_T_AVQV_PS[GRADE] : ASR_T_SLSH_RD_PS);
    localparam int C_WR = asr_cyc(ASR_T_WLWH_PS[GRADE] > ASR_T_DVWH_PS[GRADE] ?
        ASR_T_WLWH_PS[GRADE] : ASR_T_DVWH_PS[GRADE]);
    localparam int C_REC = asr_cyc(ASR_T_WHWL_PS[GRADE]);
    localparam int C_SET = asr_cyc(ASR_T_AVAX_PS[GRADE]);

    // refuse a grade with no timing set at elaboration
    if (GRADE < 0 || GRADE > 2) begin : g_bad_grade
        $error("asr_ctrl: GRADE must be 0, 1 or 2");
    end

    // the read wait carries two synchroniser cycles, so it is the longest load
    if ((C_RD + 2) >= (1 << ASR_CW) || C_SET >= (1 << ASR_CW)) begin : g_bad_timer
        $error("asr_ctrl: timer width too small");
    end

    // write pulse and recovery loads must fit the same timer
    if (C_WR >= (1 << ASR_CW) || C_REC >= (1 << ASR_CW)) begin : g_bad_pulse
        $error("asr_ctrl: timer width too small for write timing");
    end

    typedef enum {
        ST_IDLE,
        ST_RD,
        ST_CAP,
        ST_WSET,
        ST_WPULSE,
        ST_WEND,
        ST_REC
    } asr_state_t;

    typedef struct packed {
        asr_state_t state;
        logic [ASR_AW-1:0] addr;
        logic [ASR_DW-1:0] wdat;
        logic [ASR_DW-1:0] rdat;
        logic ce_n;
        logic we_n;
        logic rvalid;
        logic [ASR_DW-1:0] sync1; // first synchroniser stage, read only by sync2
        logic [ASR_DW-1:0] sync2;
    } asr_st_t;

    asr_st_t st_q, st_d;
    logic tmr_load;
    logic [ASR_CW-1:0] tmr_cnt;
    logic tmr_done;

    asr_tmr #(.CW(ASR_CW)) u_tmr (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_load(tmr_load),
        .i_count(tmr_cnt),
        .o_done(tmr_done)
    );

    // sequencer: on a write index and data are set before any control falls; a read lowers select in the same cycle as the index
    always_comb begin
        st_d = st_q;
        // read data comes from another timing world, two flops before use
        st_d.sync1 = i_output_bit;
        st_d.sync2 = st_q.sync1;
        st_d.rvalid = 1'b0;
        tmr_load = 1'b0;
        tmr_cnt = '0;
        case (st_q.state)
            ST_IDLE: begin
                if (i_req) begin
                    st_d.addr = i_addr;
                    st_d.wdat = i_wdata;
                    tmr_load = 1'b1;
                    if (i_we) begin
                        // one cycle of index setup before the first control falls
                        st_d.state = ST_WSET;
                        tmr_cnt = ASR_CW'(C_SET);
                    end else begin
                        st_d.ce_n = 1'b0;
                        st_d.state = ST_RD;
                        // two extra cycles cover the input synchroniser
                        tmr_cnt = ASR_CW'(C_RD + 2);
                    end
                end
            end
            ST_RD: begin
                if (tmr_done) begin
                    st_d.state = ST_CAP;
                end
            end
            ST_CAP: begin
                st_d.rdat = st_q.sync2;
                st_d.rvalid = 1'b1;
                st_d.ce_n = 1'b1;
                st_d.state = ST_REC;
                tmr_load = 1'b1;
                tmr_cnt = ASR_CW'(C_REC);
            end
            ST_WSET: begin
                // strobe write lowers select first, select write lowers both
                if (CS_WRITE) begin
                    st_d.we_n = 1'b0;
                    st_d.ce_n = 1'b0;
                end else if (st_q.ce_n) begin
                    st_d.ce_n = 1'b0;
                end else begin
                    st_d.we_n = 1'b0;
                end
                if (CS_WRITE || !st_q.ce_n) begin
                    st_d.state = ST_WPULSE;
                    tmr_load = 1'b1;
                    tmr_cnt = ASR_CW'(C_WR);
                end
            end
            ST_WPULSE: begin
                if (tmr_done) begin
                    // the controlling edge rises first; index and data still held
                    if (CS_WRITE) begin
                        st_d.ce_n = 1'b1;
                    end else begin
                        st_d.we_n = 1'b1;
                    end
                    st_d.state = ST_WEND;
                end
            end
            ST_WEND: begin
                st_d.ce_n = 1'b1;
                st_d.we_n = 1'b1;
                st_d.state = ST_REC;
                tmr_load = 1'b1;
                tmr_cnt = ASR_CW'(C_REC);
            end
            ST_REC: begin
                if (tmr_done) begin
                    st_d.state = ST_IDLE;
                end
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q.state <= ST_IDLE;
            st_q.addr <= '0;
            st_q.wdat <= '0;
            st_q.rdat <= '0;
            st_q.ce_n <= 1'b1;
            st_q.we_n <= 1'b1;
            st_q.rvalid <= 1'b0;
            st_q.sync1 <= '0;
            st_q.sync2 <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_ready = (st_q.state == ST_IDLE);
    assign o_rvalid = st_q.rvalid;
    assign o_rdata = st_q.rdat;
    assign o_word_index = st_q.addr;
    assign o_input_bit = st_q.wdat;
    assign o_enable_chip_low_n = st_q.ce_n;
    assign o_store_strobe_n = st_q.we_n;
endmodule : asr_ctrl

/* File: design/asr_pkg.sv */
// Behaviour
// - controller holds each index stable at least 10/12/15 ns per cycle
// - index stable early enough lets select access time govern data arrival
// - strobe write: select falls before strobe; wait strobe-to-output-low before driving (controller drives input bits from request acceptance, no wait)
// - strobe rising before select may show read data; release shared bus (controller keeps driving input bits after strobe rises)
// - strobe write keeps strobe low at least 7/8/10 ns
// - strobe low at least 7/8/10 ns before select rises
// - input bits stable 7/8/10 ns before strobe rises, free afterwards
// - index stable from strobe fall until strobe rise
// - select write: strobe falls before or with select, controls swapped
// - select write keeps select low 7/8/10 ns, strobe low as long
// - select write: data stable 7/8/10 ns before select rises, index held
// - strobe high at least 2..4 ns between strobe-controlled writes
// - select high at least 2..4 ns between select-controlled writes
// - reads keep select low at least 7 ns
package asr_pkg;
    localparam int ASR_AW = 14;
    localparam int ASR_DW = 4;
    localparam int ASR_CLK_PS = 40000;
    // timing figures in ps, index 0/1/2 = 10/12/15 ns grade
    localparam int ASR_T_AVAX_PS [3] = '{10000, 12000, 15000};
    localparam int ASR_T_AVQV_PS [3] = '{10000, 12000, 15000};
    localparam int ASR_T_WLWH_PS [3] = '{7000, 8000, 10000};
    localparam int ASR_T_DVWH_PS [3] = '{7000, 8000, 10000};
    localparam int ASR_T_WHWL_PS [3] = '{2000, 3000, 4000};
    localparam int ASR_T_WHQV_PS [3] = '{10000, 12000, 15000};
    localparam int ASR_T_SLSH_RD_PS = 7000;
    localparam int ASR_T_WLQL_PS = 5000;
    // least times round up, none below one cycle
    function automatic int asr_cyc(input int ps);
        int c;
        c = (ps + ASR_CLK_PS - 1) / ASR_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : asr_cyc
    localparam int ASR_CW = 4;
endpackage : asr_pkg

/* File: design/asr_tmr.sv */
`timescale 1ns/100ps
// down counter: o_done high once the loaded count has elapsed
module asr_tmr
    import asr_pkg::*;
#(
    parameter int CW = ASR_CW
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_load,
    input wire logic [CW-1:0] i_count,
    output logic o_done
);
    typedef struct packed {
        logic [CW-1:0] cnt;
    } asr_tmr_st_t;
    asr_tmr_st_t st_q, st_d;

    // a one-bit timer cannot hold any wait longer than a single cycle
    if (CW < 2) begin : g_bad_cw
        $error("asr_tmr: CW must be at least 2");
    end

    // load takes priority over counting down
    always_comb begin
        st_d = st_q;
        if (i_load) begin
            st_d.cnt = i_count;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_done = (st_q.cnt == '0) && !i_load;
endmodule : asr_tmr

/* File: dv/asr_ctrl_sva.sv */
`timescale 1ns/100ps
// pin order of the host controller, checked at cycle level
module asr_ctrl_sva
    import asr_pkg::*;
#(
    parameter int GRADE = 0,
    parameter bit CS_WRITE = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic o_ready,
    input wire logic [ASR_AW-1:0] o_word_index,
    input wire logic [ASR_DW-1:0] o_input_bit,
    input wire logic o_enable_chip_low_n,
    input wire logic o_store_strobe_n
);
    // short aliases keep each property on one line
    wire s_n = o_enable_chip_low_n;
    wire w_n = o_store_strobe_n;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // the two ways a write may end
    sequence s_end_by_strobe; $rose(w_n) ##1 $rose(s_n); endsequence
    sequence s_end_by_select; $rose(s_n) ##1 $rose(w_n); endsequence
    a_strobe_after_sel: assert property (!CS_WRITE && $fell(w_n) |-> $past(!s_n))
        else $error("strobe fell without select low");
    a_strobe_width: assert property (!CS_WRITE && $fell(w_n) |-> !w_n [*2])
        else $error("strobe pulse too short");
    a_strobe_end_order: assert property (!CS_WRITE && $rose(w_n) |-> s_end_by_strobe)
        else $error("select did not follow strobe release");
    a_fall_together: assert property (CS_WRITE && $fell(w_n) |-> $fell(s_n))
        else $error("strobe and select did not fall together");
    a_sel_end_order: assert property (CS_WRITE && $rose(s_n) && !w_n |-> s_end_by_select)
        else $error("strobe did not follow select release");
    a_read_sel_width: assert property ($fell(s_n) && w_n |=> !s_n)
        else $error("select low too short");
    a_select_gap: assert property ($rose(s_n) |=> s_n)
        else $error("select high gap too short");
    a_idle_quiet: assert property (o_ready |-> s_n && w_n)
        else $error("pins active while idle");
    a_write_held: assert property (!w_n |-> $stable({o_word_index, o_input_bit}))
        else $error("index or data moved during write");
    a_index_held: assert property (!s_n && $past(!s_n) |-> $stable(o_word_index))
        else $error("index moved while selected");
endmodule : asr_ctrl_sva

bind asr_ctrl asr_ctrl_sva #(.GRADE(GRADE), .CS_WRITE(CS_WRITE)) u_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_ready(o_ready), .o_word_index(o_word_index),
    .o_input_bit(o_input_bit), .o_enable_chip_low_n(o_enable_chip_low_n),
    .o_store_strobe_n(o_store_strobe_n)
);

/* File: dv/asr_sram_model.sv */
`timescale 1ns/100ps
// behavioural 16k x 4 memory; DLY is the index access time of the grade
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int DLY = 10
) (
    input wire logic [ASR_AW-1:0] i_word_index,
    input wire logic [ASR_DW-1:0] i_input_bit,
    input wire logic i_enable_chip_low_n,
    input wire logic i_store_strobe_n,
    output logic [ASR_DW-1:0] o_output_bit
);
    logic [ASR_DW-1:0] mem_q [2**ASR_AW];
    logic [ASR_DW-1:0] rd_d;
    // store when the first control rises while the other is still low
    always @(posedge i_enable_chip_low_n or posedge i_store_strobe_n) begin
        if (!(i_enable_chip_low_n && i_store_strobe_n)) mem_q[i_word_index] = i_input_bit;
    end
    // inertial delay keeps old data at least 3 ns after an index change
    assign #(DLY - 3) rd_d = mem_q[i_word_index];
    // forced low while deselected or writing, 3 ns from either control
    assign #3 o_output_bit = (i_enable_chip_low_n || !i_store_strobe_n) ? '0 : rd_d;
endmodule : asr_sram_model

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import asr_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_req = 1'b0;
    logic i_we = 1'b0;
    logic [ASR_AW-1:0] i_addr = '0;
    logic [ASR_DW-1:0] i_wdata = '0;
    logic [1:0] rdy;
    logic [1:0] rv;
    logic [ASR_DW-1:0] rd [2];
    logic [ASR_DW-1:0] ref_mem [int];
    logic [ASR_DW-1:0] exp_q [2][$];
    logic [ASR_AW-1:0] adr [$];
    int miscompares = 0;
    int checked = 0;
    int seed = 60716;
    // 25 MHz clock
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [ASR_DW-1:0] e, input logic [ASR_DW-1:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : check
    // end 0 strobe-controlled at the fast grade, end 1 select-controlled at the slow one
    for (genvar k = 0; k < 2; k++) begin : g_end
        logic [ASR_AW-1:0] idx;
        logic [ASR_DW-1:0] din;
        logic [ASR_DW-1:0] dout;
        logic sel_n;
        logic stb_n;
        asr_ctrl #(.GRADE(2 * k), .CS_WRITE(1'(k))) u_dut (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
            .i_wdata(i_wdata), .o_ready(rdy[k]), .o_rvalid(rv[k]), .o_rdata(rd[k]),
            .o_word_index(idx), .o_input_bit(din), .o_enable_chip_low_n(sel_n),
            .o_store_strobe_n(stb_n), .i_output_bit(dout));
        asr_sram_model #(.DLY(ASR_T_AVQV_PS[2 * k] / 1000)) u_mem (
            .i_word_index(idx), .i_input_bit(din), .i_enable_chip_low_n(sel_n),
            .i_store_strobe_n(stb_n), .o_output_bit(dout));
        // each read answer against the reference, in issue order
        always @(negedge i_clk) begin
            if (rv[k] === 1'b1) check("rdata", exp_q[k].pop_front(), rd[k]);
        end
    end
    task automatic wait_idle();
        for (int n = 0; n < 60 && rdy !== 2'b11; n++) @(negedge i_clk);
        check("ready", 4'h1, {3'h0, &rdy});
    endtask : wait_idle
    // one request to both ends; reads queue the reference word
    task automatic access(input logic we, input logic [ASR_AW-1:0] a, input logic [ASR_DW-1:0] d);
        wait_idle();
        i_req = 1'b1;
        i_we = we;
        i_addr = a;
        i_wdata = d;
        if (we) ref_mem[a] = d;
        else for (int k = 0; k < 2; k++) exp_q[k].push_back(ref_mem[a]);
        @(negedge i_clk);
        i_req = 1'b0;
    endtask : access
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // about 70 accesses of under 20 cycles each; six thousand cycles is ample
    initial begin
        #(40 * 6000);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        adr = '{14'h0000, 14'h3FFF};
        repeat (16) adr.push_back(14'($random(seed)));
        foreach (adr[i]) access(1'b1, adr[i], 4'($random(seed)));
        foreach (adr[i]) access(1'b0, adr[i], 4'h0);
        // every data code, written and read back to back
        for (int i = 0; i < 16; i++) begin
            access(1'b1, adr[i], 4'(i));
            access(1'b0, adr[i], 4'h0);
        end
        // reset in mid-read: pins drop back, stored words survive
        access(1'b0, adr[3], 4'h0);
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        @(negedge i_clk);
        check("idle_pins", 4'h1, {3'h0, g_end[0].sel_n & g_end[1].sel_n & (&rdy)});
        i_sys_rst = 1'b0;
        exp_q[0].delete();
        exp_q[1].delete();
        access(1'b0, adr[3], 4'h0);
        wait_idle();
        check("drained", 4'h0, 4'(exp_q[0].size() + exp_q[1].size()));
        tally_and_finish();
    end
endmodule : tb_top
